//--- rtl/clock_group_channel.v
// Purpose: One output group: divider, sync hold and coarse delay restart.
// Assumes: force_low arrives delayed by the sync latency minus one; this module's flop adds the last cycle.
// Notes:   The output drives both pins of the pair, so their timing never differs.
`timescale 1ns/10ps
`include "clock_sync_map.vh"
module clock_group_channel #(
    parameter DW = 10,
    parameter VW = 11
) (
    // Clock and reset
    input  wire          clk_sys,
    input  wire          rstn,
    // Configuration
    input  wire [DW-1:0] coarse_delay_count,
    input  wire [VW-1:0] group_divide_value,
    input  wire          sync_exclude_bit,
    // Sync control
    input  wire          force_low,
    input  wire          release_now,
    // Output
    output reg           group_out
);

    localparam ST_RUN  = 2'd0;
    localparam ST_HELD = 2'd1;
    localparam ST_WAIT = 2'd2;

    localparam [DW-1:0] MIN_DLY = `MIN_COARSE_DELAY;
    localparam [DW:0]   LAT_M1  = `SYNC_LATENCY - 1;

    reg  [1:0]    state;
    reg  [DW:0]   wait_cnt;
    reg  [VW-1:0] half_cnt;
    wire [VW-1:0] half_raw = group_divide_value >> 1;
    wire [VW-1:0] half_len = (half_raw == {VW{1'b0}}) ? {{(VW-1){1'b0}}, 1'b1} : half_raw;
    // Delays below the minimum are clamped so the earliest rise stays at latency plus five.
    wire [DW-1:0] eff_delay = (coarse_delay_count < MIN_DLY) ? MIN_DLY : coarse_delay_count;
    wire [DW:0]   load_val = {1'b0, eff_delay} + LAT_M1;

    always @(posedge clk_sys) begin
        if (!rstn) begin
            state     <= ST_RUN;
            wait_cnt  <= {(DW+1){1'b0}};
            half_cnt  <= {VW{1'b0}};
            group_out <= 1'b0;
        end else if (sync_exclude_bit) begin
            state <= ST_RUN;
            if (half_cnt == {VW{1'b0}}) begin
                group_out <= ~group_out;
                half_cnt  <= half_len - 1'b1;
            end else begin
                half_cnt <= half_cnt - 1'b1;
            end
        end else begin
            case (state)
                ST_RUN, ST_HELD: begin
                    if (release_now) begin
                        state     <= ST_WAIT;
                        wait_cnt  <= load_val;
                        group_out <= 1'b0;
                    end else if (force_low) begin
                        // The force is not aligned to the divider phase, so a short high can be cut.
                        state     <= ST_HELD;
                        group_out <= 1'b0;
                    end else if (half_cnt == {VW{1'b0}}) begin
                        state     <= ST_RUN;
                        group_out <= ~group_out;
                        half_cnt  <= half_len - 1'b1;
                    end else begin
                        state    <= ST_RUN;
                        half_cnt <= half_cnt - 1'b1;
                    end
                end
                ST_WAIT: begin
                    group_out <= 1'b0;
                    if (release_now) begin
                        wait_cnt <= load_val;
                    end else if (wait_cnt == {(DW+1){1'b0}}) begin
                        state     <= ST_RUN;
                        group_out <= 1'b1;
                        half_cnt  <= half_len - 1'b1;
                    end else begin
                        wait_cnt <= wait_cnt - 1'b1;
                    end
                end
                default: begin
                    state     <= ST_RUN;
                    group_out <= 1'b0;
                end
            endcase
        end
    end

endmodule // clock_group_channel

//--- rtl/clock_output_sync_delay.v
// Purpose: Sync request capture, qualification and per-group restart of clock outputs.
// Assumes: clk_sys is the distribution path clock; register port inputs are synchronous.
// Notes:   Half-cycle shifts are handed out as half_step; the output stage applies them.
//          Coarse delay is read live at release capture, so a write during a hold still counts.
//          A feedback select of GROUPS or more never qualifies; an armed request then waits.
//          Pair 4/5 power-down also blocks qualification, so an armed request waits for it.
`timescale 1ns/10ps
`include "clock_sync_map.vh"
module clock_output_sync_delay #(
    parameter GROUPS = 6,
    parameter DW     = 10,
    parameter VW     = 11
) (
    // Clock and reset
    input  wire              clk_sys,
    input  wire              rstn,
    // Register port
    input  wire [3:0]        reg_addr,
    input  wire [31:0]       reg_wdata,
    input  wire              reg_wr,
    input  wire              reg_rd,
    output reg  [31:0]       reg_rdata,
    // Sync pin from system logic
    input  wire              sync_pin,
    // Clock group outputs and half-step controls
    output wire [GROUPS-1:0] group_out,
    output wire [GROUPS-1:0] half_step,
    // Status
    output reg               sync_active
);

    // ------------------------------------------------------------------------
    // Local constants
    // ------------------------------------------------------------------------
    localparam LAT = `SYNC_LATENCY;

    // Sized copies of the shared counts, so no assignment narrows a plain integer.
    localparam [7:0] GLB_RST  = `RST_GLOBAL;
    localparam [1:0] AUTO_LEN = `AUTO_PULSE_LEN;
    localparam [1:0] SHOT_DLY = `ONESHOT_DELAY - 1;
    localparam [1:0] SHOT_WID = `ONESHOT_WIDTH - 1;

    // Qualification states.
    localparam Q_IDLE  = 2'd0;
    localparam Q_ARM   = 2'd1;
    localparam Q_WAIT  = 2'd2;
    localparam Q_PULSE = 2'd3;

    // ------------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------------
    reg [DW-1:0]     coarse_delay_count [0:GROUPS-1];
    reg [VW-1:0]     group_divide_value [0:GROUPS-1];
    reg [GROUPS-1:0] half_step_bit;
    reg [GROUPS-1:0] sync_exclude_bit;
    reg              sync_enable;
    reg              qualify_enable;
    reg              auto_sync_enable;
    reg              sync_polarity_invert;
    reg [2:0]        feedback_select;
    reg              pair45_power_down;

    integer i;

    // Group words sit at offsets 0 to 5, so three address bits index the per-group arrays.
    wire [2:0] grp_idx = reg_addr[2:0];
    wire group_wr = reg_wr && (reg_addr <= `REG_GROUP_LAST);
    wire glob_wr  = reg_wr && (reg_addr == `REG_GLOBAL);

    always @(posedge clk_sys) begin
        if (!rstn) begin
            for (i = 0; i < GROUPS; i = i + 1) begin
                coarse_delay_count[i] <= `RST_DELAY;
                group_divide_value[i] <= `RST_DIV;
            end
            half_step_bit        <= {GROUPS{1'b0}};
            sync_exclude_bit     <= {GROUPS{1'b0}};
            sync_enable          <= GLB_RST[`GLB_SYNC_EN_BIT];
            qualify_enable       <= 1'b0;
            auto_sync_enable     <= 1'b0;
            sync_polarity_invert <= 1'b0;
            feedback_select      <= 3'h0;
            pair45_power_down    <= 1'b0;
        end else begin
            if (group_wr) begin
                coarse_delay_count[grp_idx] <= reg_wdata[`GRP_DELAY_MSB:`GRP_DELAY_LSB];
                group_divide_value[grp_idx] <= reg_wdata[`GRP_DIV_MSB:`GRP_DIV_LSB];
                // The half step reaches its output at once; no sync event is needed.
                half_step_bit[grp_idx]      <= reg_wdata[`GRP_HALF_BIT];
                sync_exclude_bit[grp_idx]   <= reg_wdata[`GRP_EXCL_BIT];
            end
            if (glob_wr) begin
                sync_enable          <= reg_wdata[`GLB_SYNC_EN_BIT];
                qualify_enable       <= reg_wdata[`GLB_QUAL_BIT];
                auto_sync_enable     <= reg_wdata[`GLB_AUTO_BIT];
                sync_polarity_invert <= reg_wdata[`GLB_POL_INV_BIT];
                feedback_select      <= reg_wdata[`GLB_FB_SEL_MSB:`GLB_FB_SEL_LSB];
                pair45_power_down    <= reg_wdata[`GLB_P45_PD_BIT];
            end
        end
    end

    assign half_step = half_step_bit;

    // ------------------------------------------------------------------------
    // Request sources
    // ------------------------------------------------------------------------
    wire pin_level;

    // The pin is only trusted after two flops; a pulse of one period or less may be missed.
    sync_stage u_pin_sync (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .din     (sync_pin),
        .dout    (pin_level)
    );

    // Auto sync stretches a group register write into a request several cycles long.
    reg [1:0] auto_cnt;

    always @(posedge clk_sys) begin
        if (!rstn) begin
            auto_cnt <= 2'd0;
        end else if (group_wr && auto_sync_enable) begin
            auto_cnt <= AUTO_LEN;
        end else if (auto_cnt != 2'd0) begin
            auto_cnt <= auto_cnt - 2'd1;
        end
    end

    // Flipping the invert bit flips the effective level, which itself is a request.
    wire eff_pin  = pin_level ^ sync_polarity_invert;
    wire auto_req = (auto_cnt != 2'd0);
    wire raw_req  = sync_enable & (eff_pin | auto_req);

    // ------------------------------------------------------------------------
    // Qualification by an output clock
    // ------------------------------------------------------------------------
    reg       raw_prev;
    reg       fb_prev;
    reg [1:0] q_state;
    reg [1:0] q_cnt;
    reg       req_q;
    reg [1:0] next_q_state;
    reg [1:0] next_q_cnt;
    reg       next_req;

    // The qualifier is taken from the selected group; pair 4/5 must stay powered for this.
    wire fb_now  = (feedback_select < GROUPS) ? group_out[feedback_select] : 1'b0;
    wire fb_fall = fb_prev & ~fb_now & ~pair45_power_down;

    // An excluded qualifier keeps running (absolute); an included one is resynced too (relative).
    wire fb_is_excluded = (feedback_select < GROUPS) ? sync_exclude_bit[feedback_select] : 1'b1;

    // The one-shot is timed from the registered fall of the qualifier, so the restart keeps
    // a fixed distance to that clock whatever the timing of the request itself was.
    always @* begin
        next_q_state = q_state;
        next_q_cnt   = q_cnt;
        next_req     = req_q;
        if (!sync_enable) begin
            next_q_state = Q_IDLE;
            next_q_cnt   = 2'd0;
            next_req     = 1'b0;
        end else if (!qualify_enable) begin
            // Unqualified, restarted groups land at no known phase to excluded ones.
            next_q_state = Q_IDLE;
            next_req     = raw_req;
        end else begin
            case (q_state)
                Q_IDLE: begin
                    next_req = 1'b0;
                    if (raw_req && !raw_prev) begin
                        next_q_state = Q_ARM;
                    end
                end
                Q_ARM: begin
                    if (fb_fall) begin
                        next_q_state = Q_WAIT;
                        next_q_cnt   = SHOT_DLY;
                    end
                end
                Q_WAIT: begin
                    if (q_cnt == 2'd0) begin
                        next_q_state = Q_PULSE;
                        next_q_cnt   = SHOT_WID;
                        next_req     = 1'b1;
                    end else begin
                        next_q_cnt = q_cnt - 2'd1;
                    end
                end
                Q_PULSE: begin
                    if (q_cnt == 2'd0) begin
                        next_q_state = Q_IDLE;
                        next_req     = 1'b0;
                    end else begin
                        next_q_cnt = q_cnt - 2'd1;
                    end
                end
                default: begin
                    next_q_state = Q_IDLE;
                    next_req     = 1'b0;
                end
            endcase
        end
    end

    always @(posedge clk_sys) begin
        if (!rstn) begin
            raw_prev <= 1'b0;
            fb_prev  <= 1'b0;
            q_state  <= Q_IDLE;
            q_cnt    <= 2'd0;
            req_q    <= 1'b0;
        end else begin
            raw_prev <= raw_req;
            fb_prev  <= fb_now;
            q_state  <= next_q_state;
            q_cnt    <= next_q_cnt;
            req_q    <= next_req;
        end
    end

    // ------------------------------------------------------------------------
    // Latency pipeline and release capture
    // ------------------------------------------------------------------------
    // The captured request walks LAT-1 stages; the channel flop adds the last cycle.
    // A request shorter than the pipeline still restarts the groups, since release wins over force.
    reg  [LAT-2:0] hold_sr;
    wire           release_now = req_q & ~next_req;

    always @(posedge clk_sys) begin
        if (!rstn) begin
            hold_sr <= {(LAT-1){1'b0}};
        end else begin
            hold_sr <= {hold_sr[LAT-3:0], req_q};
        end
    end

    // ------------------------------------------------------------------------
    // Output groups
    // ------------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < GROUPS; g = g + 1) begin : gen_group
            // One channel per divider drives both pins of its pair.
            clock_group_channel #(
                .DW (DW),
                .VW (VW)
            ) u_channel (
                .clk_sys            (clk_sys),
                .rstn               (rstn),
                .coarse_delay_count (coarse_delay_count[g]),
                .group_divide_value (group_divide_value[g]),
                .sync_exclude_bit   (sync_exclude_bit[g]),
                .force_low          (hold_sr[LAT-2]),
                .release_now        (release_now),
                .group_out          (group_out[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------------------
    // Register read-back
    // ------------------------------------------------------------------------
    // Each word is built apart from the mux, so field positions can be checked against the map.
    wire [31:0] group_word  = {5'h00, group_divide_value[grp_idx], 4'h0,
                               sync_exclude_bit[grp_idx], half_step_bit[grp_idx],
                               coarse_delay_count[grp_idx]};
    wire [31:0] global_word = {24'h00_0000, pair45_power_down, feedback_select,
                               sync_polarity_invert, auto_sync_enable, qualify_enable, sync_enable};
    wire [31:0] status_word = {16'h0000, 3'h0, fb_is_excluded, q_state, req_q, pin_level,
                               {(8-GROUPS){1'b0}}, group_out};

    // The status copy trails the internal request by one cycle.
    always @(posedge clk_sys) begin
        if (!rstn) begin
            sync_active <= 1'b0;
        end else begin
            sync_active <= req_q;
        end
    end

    // Read data stand for one cycle only and are zero otherwise.
    always @(posedge clk_sys) begin
        if (!rstn) begin
            reg_rdata <= 32'h0000_0000;
        end else begin
            if (reg_rd) begin
                if (reg_addr <= `REG_GROUP_LAST) begin
                    reg_rdata <= group_word;
                end else if (reg_addr == `REG_GLOBAL) begin
                    reg_rdata <= global_word;
                end else if (reg_addr == `REG_STATUS) begin
                    reg_rdata <= status_word;
                end else begin
                    reg_rdata <= 32'h0000_0000;
                end
            end else begin
                reg_rdata <= 32'h0000_0000;
            end
        end
    end

endmodule // clock_output_sync_delay

//--- rtl/clock_sync_map.vh
// Purpose: Offsets, field positions, reset values and timing counts for the clock output sync block.
// Assumes: One clock, the distribution path clock; register port with one-cycle read latency.
// Notes:   Definitions only.
`ifndef CLOCK_SYNC_MAP_VH
`define CLOCK_SYNC_MAP_VH

// ----------------------------------------------------------------------------
// Register offsets (word index on the register port)
// ----------------------------------------------------------------------------
`define REG_GROUP_LAST     4'h5
`define REG_GLOBAL         4'h6
`define REG_STATUS         4'h7

// ----------------------------------------------------------------------------
// Group register fields
// ----------------------------------------------------------------------------
`define GRP_DELAY_LSB      0
`define GRP_DELAY_MSB      9
`define GRP_HALF_BIT       10
`define GRP_EXCL_BIT       11
`define GRP_DIV_LSB        16
`define GRP_DIV_MSB        26

// ----------------------------------------------------------------------------
// Global register fields
// ----------------------------------------------------------------------------
`define GLB_SYNC_EN_BIT    0
`define GLB_QUAL_BIT       1
`define GLB_AUTO_BIT       2
`define GLB_POL_INV_BIT    3
`define GLB_FB_SEL_LSB     4
`define GLB_FB_SEL_MSB     6
`define GLB_P45_PD_BIT     7

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define RST_DELAY          10'h005
`define RST_DIV            11'h004
`define RST_GLOBAL         8'h01

// ----------------------------------------------------------------------------
// Timing counts in distribution path cycles
// ----------------------------------------------------------------------------
`define SYNC_LATENCY       6
`define MIN_COARSE_DELAY   5
`define ONESHOT_DELAY      3
`define ONESHOT_WIDTH      3
`define AUTO_PULSE_LEN     3

`endif

//--- rtl/sync_stage.v
// Purpose: Two-flop synchronizer for an asynchronous level.
// Assumes: Only the second flop is read outside this module.
// Notes:   Synchronous active-low reset clears both flops.
`timescale 1ns/10ps
module sync_stage (
    // Clock and reset
    input  wire clk_sys,
    input  wire rstn,
    // Level in and out
    input  wire din,
    output reg  dout
);

    reg meta;

    always @(posedge clk_sys) begin
        if (!rstn) begin
            meta <= 1'b0;
            dout <= 1'b0;
        end else begin
            meta <= din;
            dout <= meta;
        end
    end

endmodule // sync_stage

//--- testbench/clock_output_sync_delay_properties.sv
// Purpose: Concurrent checks on the ports of the clock output sync block.
// Assumes: Group exclude bits and global settings are shadowed from register port writes.
// Notes:   The exclusion check assumes divide 4 on group 5, as the bench keeps it.
`timescale 1ns/10ps
module clock_sync_checker #(
    parameter GROUPS = 6
) (
    input wire              clk_sys,
    input wire              rstn,
    input wire [3:0]        reg_addr,
    input wire [31:0]       reg_wdata,
    input wire              reg_wr,
    input wire              reg_rd,
    input wire [31:0]       reg_rdata,
    input wire              sync_pin,
    input wire [GROUPS-1:0] group_out,
    input wire [GROUPS-1:0] half_step,
    input wire              sync_active
);
    reg [GROUPS-1:0] excl;
    reg [7:0]        glb;

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    // Shadow copies let the checks know which groups and modes are live.
    always @(posedge clk_sys) begin
        if (!rstn) begin
            excl <= '0;
            glb  <= 8'h01;
        end else if (reg_wr && reg_addr < 4'h6) begin
            excl[reg_addr] <= reg_wdata[11];
        end else if (reg_wr && reg_addr == 4'h6) begin
            glb <= reg_wdata[7:0];
        end
    end

    hold_low_a: assert property ($rose(sync_active) |-> ##5 ((group_out & ~excl) == '0)[*6])
        else $error("selected groups not held low after capture");
    rise_wait_a: assert property ($fell(sync_active) |-> ((group_out & ~excl) == '0)[*8])
        else $error("group restarted before the minimum restart delay");
    exclude_run_a: assert property (excl[5] && $stable(group_out[5]) |=> $changed(group_out[5]))
        else $error("excluded group stopped toggling");
    sync_gate_a: assert property (!glb[0] && !sync_active |=> !sync_active)
        else $error("sync taken while sync handling disabled");
    pin_take_a: assert property (glb[0] && !glb[1] && $rose(sync_pin ^ glb[3]) |-> ##[2:5] sync_active)
        else $error("manual request not captured in time");
    auto_take_a: assert property (glb[0] && glb[2] && !glb[1] && reg_wr && reg_addr < 4'h6 |-> ##[2:5] sync_active)
        else $error("group write did not start an auto sync");
    half_now_a: assert property (reg_wr && reg_addr < 4'h6 |=> half_step[$past(reg_addr)] == $past(reg_wdata[10]))
        else $error("half step did not follow the write at once");
    qual_shot_a: assert property ($rose(sync_active) && glb[1] |-> sync_active[*3] ##1 !sync_active)
        else $error("qualified one-shot not three cycles wide");
    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
        else $error("read data present outside the read answer cycle");
endmodule // clock_sync_checker

bind clock_output_sync_delay clock_sync_checker #(.GROUPS(GROUPS)) u_props (.clk_sys(clk_sys), .rstn(rstn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .sync_pin(sync_pin), .group_out(group_out), .half_step(half_step), .sync_active(sync_active));

//--- testbench/sync_driver.sv
// Purpose: System logic that pulses the sync pin on request of the bench.
// Assumes: The pin is actively driven at both levels, so it never floats.
// Notes:   Pulses shorter than two cycles are stretched, since shorter ones may be missed.
`timescale 1ns/10ps
module sync_driver (
    // Clock
    input  wire       clk_sys,
    // Request from the bench
    input  wire       go,
    input  wire [7:0] len,
    // Pin toward the device
    output reg        sync_pin
);
    reg [7:0] left = 8'h00;

    initial sync_pin = 1'b0;

    always @(posedge clk_sys) begin
        if (go) begin
            left     <= (len < 8'h02) ? 8'h02 : len;
            sync_pin <= 1'b1;
        end else if (left > 8'h01) begin
            left <= left - 8'h01;
        end else begin
            left     <= 8'h00;
            sync_pin <= 1'b0;
        end
    end
endmodule // sync_driver

//--- testbench/tb_clock_output_sync_delay.sv
// Purpose: Self-checking bench for the clock output sync block.
// Assumes: Group 5 stays excluded at divide 4; group 0 restart time is scored.
// Notes:   Read data and restart delays are noted in queues and scored by a monitor.
`timescale 1ns/10ps
`include "clock_sync_map.vh"
`define CHK(a, e) \
    begin \
        checks_done = checks_done + 1; \
        if ((a) !== (e)) begin \
            err_count = err_count + 1; \
            $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (a), (e)); \
        end \
    end
module tb_clock_output_sync_delay;
    reg         clk_sys = 1'b0;
    reg         rstn = 1'b0;
    reg  [3:0]  reg_addr = 4'h0;
    reg  [31:0] reg_wdata = 32'h0000_0000;
    reg         reg_wr = 1'b0;
    reg         reg_rd = 1'b0;
    wire [31:0] reg_rdata;
    wire        sync_pin;
    wire [5:0]  group_out;
    wire [5:0]  half_step;
    wire        sync_active;
    reg         pulse_go = 1'b0;
    integer     err_count = 0;
    integer     checks_done = 0;
    integer     seed = 1;
    integer     cnt = -1;
    integer     d;
    integer     e_v;
    reg  [31:0] r_v;
    reg  [31:0] w;
    reg  [31:0] exp_rd[$];
    integer     exp_rise[$];
    reg         rd_q = 1'b0;
    reg         act_q = 1'b0;
    reg         g0_q = 1'b0;

    always #25 clk_sys = ~clk_sys;

    clock_output_sync_delay u_dut (.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sync_pin(sync_pin), .group_out(group_out),
        .half_step(half_step), .sync_active(sync_active));
    sync_driver u_sys (.clk_sys(clk_sys), .go(pulse_go), .len(8'h04), .sync_pin(sync_pin));

    task bus(input is_rd, input [3:0] a, input [31:0] v);
        begin
            if (is_rd) exp_rd.push_back(v);
            reg_addr  <= a;
            reg_wdata <= v;
            reg_wr    <= !is_rd;
            reg_rd    <= is_rd;
            @(posedge clk_sys);
            reg_wr    <= 1'b0;
            reg_rd    <= 1'b0;
            @(posedge clk_sys);
        end
    endtask

    task pulse;
        begin
            pulse_go <= 1'b1;
            @(posedge clk_sys);
            pulse_go <= 1'b0;
        end
    endtask

    // The monitor sees the fall of sync_active one cycle after capture, hence the minus one.
    task expect_rise(input integer dly);
        exp_rise.push_back(`SYNC_LATENCY + ((dly < `MIN_COARSE_DELAY) ? `MIN_COARSE_DELAY : dly) - 1);
    endtask

    task wait_rise;
        integer i;
        begin
            for (i = 0; i < 80 && exp_rise.size() != 0; i = i + 1) @(posedge clk_sys);
        end
    endtask

    task tally_and_finish;
        begin
            $display("checks_done=%0d err_count=%0d", checks_done, err_count);
            if (err_count == 0 && checks_done > 0) begin
                $display("RESULT: PASS");
            end else begin
                $display("RESULT: FAIL");
            end
            $finish;
        end
    endtask

    always @(posedge clk_sys) begin
        if (rd_q) begin
            r_v = exp_rd.pop_front();
            `CHK(reg_rdata, r_v)
        end
        if (act_q && !sync_active) cnt = 0;
        else if (cnt >= 0) cnt = cnt + 1;
        if (cnt >= 0 && group_out[0] && !g0_q && exp_rise.size() != 0) begin
            e_v = exp_rise.pop_front();
            `CHK(cnt, e_v)
            cnt = -1;
        end
        rd_q  <= reg_rd;
        act_q <= sync_active;
        g0_q  <= group_out[0];
    end

    initial begin
        repeat (20) @(posedge clk_sys);
        rstn <= 1'b1;
        @(posedge clk_sys);
        bus(1, `REG_GLOBAL, 32'h0000_0001);
        bus(1, 4'h0, 32'h0004_0005);
        bus(1, 4'hA, 32'h0000_0000);
        w = ($random(seed) & 32'h07FF_0FFF) | 32'h0000_0008;
        bus(0, 4'h1, w);
        bus(1, 4'h1, w);
        `CHK(half_step[1], w[10])
        bus(0, 4'h5, 32'h0004_0805);
        for (d = 4; d <= 10; d = d + 3) begin
            bus(0, 4'h0, {16'h0004, 6'h00, d[9:0]});
            expect_rise(d);
            pulse;
            wait_rise;
        end
        expect_rise(10);
        bus(0, `REG_GLOBAL, 32'h0000_0009);
        repeat (4) @(posedge clk_sys);
        bus(0, `REG_GLOBAL, 32'h0000_0001);
        wait_rise;
        bus(0, `REG_GLOBAL, 32'h0000_0005);
        expect_rise(6);
        bus(0, 4'h0, 32'h0004_0006);
        wait_rise;
        bus(0, `REG_GLOBAL, 32'h0000_0000);
        pulse;
        repeat (12) @(posedge clk_sys);
        `CHK(sync_active, 1'b0)
        `CHK(cnt, -1)
        bus(0, `REG_GLOBAL, 32'h0000_0053);
        expect_rise(6);
        pulse;
        wait_rise;
        // Group 0 qualifies its own restart, so it must come back after its own delay.
        bus(0, `REG_GLOBAL, 32'h0000_0003);
        expect_rise(6);
        pulse;
        wait_rise;
        bus(0, `REG_GLOBAL, 32'h0000_0073);
        pulse;
        repeat (20) @(posedge clk_sys);
        `CHK(sync_active, 1'b0)
        `CHK(cnt, -1)
        // The request stays armed; a powered-down pair 4/5 must keep group 5 from firing it.
        bus(0, `REG_GLOBAL, 32'h0000_00D3);
        repeat (20) @(posedge clk_sys);
        `CHK(cnt, -1)
        `CHK(exp_rise.size(), 0)
        tally_and_finish;
    end

    initial begin
        repeat (5000) @(posedge clk_sys);
        err_count = err_count + 1;
        tally_and_finish;
    end
endmodule // tb_clock_output_sync_delay
